// ==== design/spec_cfg.svh ====
// Constants of the step pulse and encoder configuration block
`ifndef SPEC_CFG_SVH
`define SPEC_CFG_SVH

`define SPEC_NUM_AXES        4
`define SPEC_AXIS_REGION_HI  4'h3
`define SPEC_OFS_CFG         4'h0
`define SPEC_OFS_STEP        4'h4
`define SPEC_OFS_COUNT       4'h8
`define SPEC_OFS_STATUS      4'hC
`define SPEC_ADDR_VERSION    8'h80
// Arbitrary version value
`define SPEC_VERSION_VALUE   32'h0000_0001

`define SPEC_CFG_RESET       7'h00
`define SPEC_CFG_OUT_LSB     0
`define SPEC_CFG_IPT_LSB     3
`define SPEC_CFG_POL_BIT     5
`define SPEC_CFG_SRC_BIT     6
`define SPEC_STEP_NEG_BIT    0
`define SPEC_ST_BUSY_BIT     0
`define SPEC_ST_REJECT_BIT   1
`define SPEC_ST_ENCERR_BIT   2
`define SPEC_ST_ENCA_BIT     3
`define SPEC_ST_ENCB_BIT     4

`define SPEC_COUNT_RESET     32'h0000_0000
`define SPEC_LINE_RESET      1'b1

`define SPEC_CLK_NS          40
`define SPEC_PULSE_NS        1000
`define SPEC_PULSE_CYC       ((`SPEC_PULSE_NS + `SPEC_CLK_NS - 1) / `SPEC_CLK_NS)

`endif

// ==== design/spec_enc_decode.sv ====
// Encoder phase decoder producing one-cycle up and down counts
`timescale 1ns/1ps
`default_nettype none
module spec_enc_decode (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire spec_pkg::spec_axis_cfg_t cfg,
  input  wire spec_pkg::spec_enc_t      enc,
  output logic                          up,
  output logic                          down,
  output logic                          bad_edge
);
  import spec_pkg::*;

  spec_enc_t prev_q;
  spec_enc_t prev_d;
  logic      up_q;
  logic      up_d;
  logic      down_q;
  logic      down_d;
  logic      bad_q;
  logic      bad_d;
  spec_enc_t now_n;
  spec_enc_t old_n;
  logic      ea;
  logic      eb;

  always_comb begin
    // Old and new samples see the same polarity, so a polarity change makes no false edge
    now_n  = enc ^ {2{cfg.idle_high}};
    old_n  = prev_q ^ {2{cfg.idle_high}};
    ea     = now_n.a ^ old_n.a;
    eb     = now_n.b ^ old_n.b;
    prev_d = enc;
    up_d   = 1'b0;
    down_d = 1'b0;
    bad_d  = 1'b0;
    unique case (cfg.ipt)
      SPEC_IN_QUAD_1X: begin
        if (ea && !eb && !now_n.b) begin
          up_d   = now_n.a;
          down_d = !now_n.a;
        end
        bad_d = ea & eb;
      end
      SPEC_IN_QUAD_2X: begin
        if (ea && !eb) begin
          up_d   = now_n.a != now_n.b;
          down_d = now_n.a == now_n.b;
        end
        bad_d = ea & eb;
      end
      SPEC_IN_QUAD_4X: begin
        if (ea && !eb) begin
          up_d   = now_n.a != now_n.b;
          down_d = now_n.a == now_n.b;
        end else if (eb && !ea) begin
          up_d   = now_n.a == now_n.b;
          down_d = now_n.a != now_n.b;
        end
        bad_d = ea & eb;
      end
      SPEC_IN_PULSE_PAIR: begin
        up_d   = ea & now_n.a;
        down_d = eb & now_n.b;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_q <= 2'b00;
      up_q   <= 1'b0;
      down_q <= 1'b0;
      bad_q  <= 1'b0;
    end else begin
      prev_q <= prev_d;
      up_q   <= up_d;
      down_q <= down_d;
      bad_q  <= bad_d;
    end
  end

  assign up       = up_q;
  assign down     = down_q;
  assign bad_edge = bad_q;

endmodule
`default_nettype wire

// ==== design/spec_pkg.sv ====
// Types of the step pulse and encoder configuration block
`default_nettype none
package spec_pkg;

  typedef enum logic [2:0] {
    SPEC_OUT_DIR_FALL_POSHI = 3'b000,
    SPEC_OUT_DIR_RISE_POSHI = 3'b001,
    SPEC_OUT_DIR_FALL_POSLO = 3'b010,
    SPEC_OUT_DIR_RISE_POSLO = 3'b011,
    SPEC_OUT_PAIR_FALL      = 3'b100,
    SPEC_OUT_PAIR_RISE      = 3'b101,
    SPEC_OUT_QUAD_LEAD      = 3'b110,
    SPEC_OUT_QUAD_LAG       = 3'b111
  } spec_outmode_t;

  typedef enum logic [1:0] {
    SPEC_IN_QUAD_1X   = 2'b00,
    SPEC_IN_QUAD_2X   = 2'b01,
    SPEC_IN_QUAD_4X   = 2'b10,
    SPEC_IN_PULSE_PAIR = 2'b11
  } spec_iptmode_t;

  typedef struct packed {
    logic          src_cmd;
    logic          idle_high;
    spec_iptmode_t ipt;
    spec_outmode_t out;
  } spec_axis_cfg_t;

  typedef struct packed {
    logic a;
    logic b;
  } spec_enc_t;

  typedef enum logic [1:0] {
    SPEC_ST_IDLE   = 2'b00,
    SPEC_ST_LEAD   = 2'b01,
    SPEC_ST_ACTIVE = 2'b10,
    SPEC_ST_GAP    = 2'b11
  } spec_step_st_t;

endpackage
`default_nettype wire

// ==== design/spec_top.sv ====
// Per-axis command pulse generator, encoder counter and register port
`timescale 1ns/1ps
`default_nettype none
`include "spec_cfg.svh"
module spec_top (
  input  wire logic                      CLOCK,
  input  wire logic                      RST_B,
  input  wire logic [7:0]                ADDR,
  input  wire logic [31:0]               WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  output logic      [31:0]               RDATA,
  output logic      [`SPEC_NUM_AXES-1:0] CMD_LINE_A,
  output logic      [`SPEC_NUM_AXES-1:0] CMD_LINE_B,
  input  wire logic [`SPEC_NUM_AXES-1:0] ENCODER_PHASE_A,
  input  wire logic [`SPEC_NUM_AXES-1:0] ENCODER_PHASE_B
);
  import spec_pkg::*;

  localparam int NA = `SPEC_NUM_AXES;
  localparam logic [4:0] PULSE_RELOAD = 5'(`SPEC_PULSE_CYC - 1);

  // Register port decode
  function automatic logic axis_hit(input logic [7:0] a, input int idx);
    axis_hit = (a[7:4] == 4'(idx)) && (a[7:4] <= `SPEC_AXIS_REGION_HI);
  endfunction

  // Up/down step with modulo 2^32 wrap
  function automatic logic [31:0] next_count(input logic [31:0] c,
                                             input logic inc,
                                             input logic dec);
    next_count = c;
    if (inc && !dec) begin
      next_count = c + 32'h0000_0001;
    end else if (dec && !inc) begin
      next_count = c - 32'h0000_0001;
    end
  endfunction

  // Line levels for one axis from format, step phase and direction
  function automatic logic [1:0] line_levels(input spec_outmode_t m,
                                             input logic act,
                                             input logic neg,
                                             input logic [1:0] ph);
    logic qa;
    logic qb;
    qa = ph[1] ^ ph[0];
    qb = ph[1];
    line_levels = 2'b11;
    unique case (m)
      SPEC_OUT_DIR_FALL_POSHI,
      SPEC_OUT_DIR_RISE_POSHI,
      SPEC_OUT_DIR_FALL_POSLO,
      SPEC_OUT_DIR_RISE_POSLO: begin
        // Even codes idle high and step on a falling edge
        line_levels[1] = m[0] ? act : !act;
        line_levels[0] = neg ^ !m[1];
      end
      SPEC_OUT_PAIR_FALL,
      SPEC_OUT_PAIR_RISE: begin
        line_levels[1] = (act & !neg) ^ !m[0];
        line_levels[0] = (act & neg) ^ !m[0];
      end
      SPEC_OUT_QUAD_LEAD: begin
        line_levels = {qa, qb};
      end
      SPEC_OUT_QUAD_LAG: begin
        line_levels = {qb, qa};
      end
    endcase
  endfunction

  spec_axis_cfg_t cfg_q    [NA];
  spec_axis_cfg_t cfg_d    [NA];
  logic [31:0]    count_q  [NA];
  logic [31:0]    count_d  [NA];
  spec_step_st_t  st_q     [NA];
  spec_step_st_t  st_d     [NA];
  logic [4:0]     tmr_q    [NA];
  logic [4:0]     tmr_d    [NA];
  logic           neg_q    [NA];
  logic           neg_d    [NA];
  logic [1:0]     phase_q  [NA];
  logic [1:0]     phase_d  [NA];
  logic           reject_q [NA];
  logic           reject_d [NA];
  logic           encerr_q [NA];
  logic           encerr_d [NA];
  logic           fire     [NA];
  logic [NA-1:0]  line_a_q;
  logic [NA-1:0]  line_a_d;
  logic [NA-1:0]  line_b_q;
  logic [NA-1:0]  line_b_d;
  logic [31:0]    rdata_q;
  logic [31:0]    rdata_d;
  logic           dec_up   [NA];
  logic           dec_down [NA];
  logic           dec_bad  [NA];

  // One decoder per axis, each reading only its own settings
  for (genvar g = 0; g < NA; g++) begin : g_dec
    spec_enc_decode u_dec (
      .clk      (CLOCK),
      .rst_b    (RST_B),
      .cfg      (cfg_q[g]),
      .enc      ({ENCODER_PHASE_A[g], ENCODER_PHASE_B[g]}),
      .up       (dec_up[g]),
      .down     (dec_down[g]),
      .bad_edge (dec_bad[g])
    );
  end

  // Configuration, counters and status flags
  always_comb begin
    logic inc;
    logic dec;
    logic hit;
    inc = 1'b0;
    dec = 1'b0;
    hit = 1'b0;
    for (int i = 0; i < NA; i++) begin
      cfg_d[i]    = cfg_q[i];
      reject_d[i] = reject_q[i];
      encerr_d[i] = encerr_q[i];
      hit = axis_hit(ADDR, i);
      if (WR && hit && ADDR[3:0] == `SPEC_OFS_CFG) begin
        // Only this axis's copy is touched
        cfg_d[i].out       = spec_outmode_t'(WDATA[`SPEC_CFG_OUT_LSB +: 3]);
        cfg_d[i].ipt       = spec_iptmode_t'(WDATA[`SPEC_CFG_IPT_LSB +: 2]);
        cfg_d[i].idle_high = WDATA[`SPEC_CFG_POL_BIT];
        cfg_d[i].src_cmd   = WDATA[`SPEC_CFG_SRC_BIT];
      end
      // Write-one clears; a new event in the same cycle keeps the flag
      if (WR && hit && ADDR[3:0] == `SPEC_OFS_STATUS) begin
        if (WDATA[`SPEC_ST_REJECT_BIT]) begin
          reject_d[i] = 1'b0;
        end
        if (WDATA[`SPEC_ST_ENCERR_BIT]) begin
          encerr_d[i] = 1'b0;
        end
      end
      if (WR && hit && ADDR[3:0] == `SPEC_OFS_STEP && st_q[i] != SPEC_ST_IDLE) begin
        reject_d[i] = 1'b1;
      end
      if (dec_bad[i] && !cfg_q[i].src_cmd) begin
        encerr_d[i] = 1'b1;
      end
      // Decoder output is ignored when counting command pulses
      if (cfg_q[i].src_cmd) begin
        inc = fire[i] & !neg_q[i];
        dec = fire[i] & neg_q[i];
      end else begin
        inc = dec_up[i];
        dec = dec_down[i];
      end
      if (WR && hit && ADDR[3:0] == `SPEC_OFS_COUNT) begin
        count_d[i] = WDATA;
      end else begin
        count_d[i] = next_count(count_q[i], inc, dec);
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    for (int i = 0; i < NA; i++) begin
      if (!RST_B) begin
        cfg_q[i]    <= spec_axis_cfg_t'(`SPEC_CFG_RESET);
        count_q[i]  <= `SPEC_COUNT_RESET;
        reject_q[i] <= 1'b0;
        encerr_q[i] <= 1'b0;
      end else begin
        cfg_q[i]    <= cfg_d[i];
        count_q[i]  <= count_d[i];
        reject_q[i] <= reject_d[i];
        encerr_q[i] <= encerr_d[i];
      end
    end
  end

  // Step sequencer: direction settles for a pulse width before the edge
  always_comb begin
    for (int i = 0; i < NA; i++) begin
      st_d[i]    = st_q[i];
      tmr_d[i]   = tmr_q[i];
      neg_d[i]   = neg_q[i];
      phase_d[i] = phase_q[i];
      fire[i]    = 1'b0;
      unique case (st_q[i])
        SPEC_ST_IDLE: begin
          if (WR && axis_hit(ADDR, i) && ADDR[3:0] == `SPEC_OFS_STEP) begin
            neg_d[i] = WDATA[`SPEC_STEP_NEG_BIT];
            tmr_d[i] = PULSE_RELOAD;
            st_d[i]  = SPEC_ST_LEAD;
          end
        end
        SPEC_ST_LEAD: begin
          if (tmr_q[i] == 5'h00) begin
            fire[i]  = 1'b1;
            tmr_d[i] = PULSE_RELOAD;
            st_d[i]  = SPEC_ST_ACTIVE;
            // Quadrature steps move a quarter period per step
            phase_d[i] = neg_q[i] ? phase_q[i] - 2'h1 : phase_q[i] + 2'h1;
          end else begin
            tmr_d[i] = tmr_q[i] - 5'h01;
          end
        end
        SPEC_ST_ACTIVE: begin
          if (tmr_q[i] == 5'h00) begin
            tmr_d[i] = PULSE_RELOAD;
            st_d[i]  = SPEC_ST_GAP;
          end else begin
            tmr_d[i] = tmr_q[i] - 5'h01;
          end
        end
        SPEC_ST_GAP: begin
          if (tmr_q[i] == 5'h00) begin
            st_d[i] = SPEC_ST_IDLE;
          end else begin
            tmr_d[i] = tmr_q[i] - 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    for (int i = 0; i < NA; i++) begin
      if (!RST_B) begin
        st_q[i]    <= SPEC_ST_IDLE;
        tmr_q[i]   <= 5'h00;
        neg_q[i]   <= 1'b0;
        phase_q[i] <= 2'h0;
      end else begin
        st_q[i]    <= st_d[i];
        tmr_q[i]   <= tmr_d[i];
        neg_q[i]   <= neg_d[i];
        phase_q[i] <= phase_d[i];
      end
    end
  end

  // Output lines, registered so the pins never glitch
  always_comb begin
    logic [1:0] lv;
    lv = 2'b11;
    for (int i = 0; i < NA; i++) begin
      lv = line_levels(cfg_q[i].out, st_q[i] == SPEC_ST_ACTIVE, neg_q[i], phase_q[i]);
      line_a_d[i] = lv[1];
      line_b_d[i] = lv[0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      line_a_q <= {NA{`SPEC_LINE_RESET}};
      line_b_q <= {NA{`SPEC_LINE_RESET}};
    end else begin
      line_a_q <= line_a_d;
      line_b_q <= line_b_d;
    end
  end

  // Read data stands in the cycle after the strobe only
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (RD) begin
      if (ADDR == `SPEC_ADDR_VERSION) begin
        rdata_d = `SPEC_VERSION_VALUE;
      end
      for (int i = 0; i < NA; i++) begin
        if (axis_hit(ADDR, i)) begin
          unique case (ADDR[3:0])
            `SPEC_OFS_CFG: begin
              rdata_d = {25'h0000000, cfg_q[i]};
            end
            `SPEC_OFS_COUNT: begin
              rdata_d = count_q[i];
            end
            `SPEC_OFS_STATUS: begin
              rdata_d[`SPEC_ST_BUSY_BIT]   = st_q[i] != SPEC_ST_IDLE;
              rdata_d[`SPEC_ST_REJECT_BIT] = reject_q[i];
              rdata_d[`SPEC_ST_ENCERR_BIT] = encerr_q[i];
              rdata_d[`SPEC_ST_ENCA_BIT]   = ENCODER_PHASE_A[i];
              rdata_d[`SPEC_ST_ENCB_BIT]   = ENCODER_PHASE_B[i];
            end
            default: begin
              rdata_d = 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA      = rdata_q;
  assign CMD_LINE_A = line_a_q;
  assign CMD_LINE_B = line_b_q;

endmodule
`default_nettype wire

// ==== test/spec_far_model.sv ====
// Drive and encoder model: counts line edges, walks encoder phases
`timescale 1ns/1ps
`default_nettype none
module spec_far_model (
  input  wire logic       CLOCK,
  input  wire logic [3:0] CMD_LINE_A,
  input  wire logic [3:0] CMD_LINE_B,
  output logic      [3:0] ENCODER_PHASE_A,
  output logic      [3:0] ENCODER_PHASE_B
);
  logic [3:0] a_q;
  logic [3:0] b_q;
  int         edges [4];
  initial begin
    ENCODER_PHASE_A = 4'h0;
    ENCODER_PHASE_B = 4'h0;
    a_q = 4'hF;
    b_q = 4'hF;
    edges = '{0, 0, 0, 0};
  end
  always @(posedge CLOCK) begin
    for (int i = 0; i < 4; i++) begin
      edges[i] += int'(CMD_LINE_A[i] != a_q[i]) + int'(CMD_LINE_B[i] != b_q[i]);
    end
    a_q <= CMD_LINE_A;
    b_q <= CMD_LINE_B;
  end
  // Four phase states per round, msb pair first; each held 4 cycles
  task walk(input int ax, input logic inv, input int n, input logic [7:0] pat);
    for (int i = 0; i < n; i++) begin
      for (int k = 3; k >= 0; k--) begin
        @(posedge CLOCK);
        ENCODER_PHASE_A[ax] <= pat[2 * k + 1] ^ inv;
        ENCODER_PHASE_B[ax] <= pat[2 * k] ^ inv;
        repeat (3) @(posedge CLOCK);
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== test/spec_top_bench.sv ====
// Self-checking bench for the step pulse and encoder block
`timescale 1ns/1ps
`default_nettype none
`include "spec_cfg.svh"
module spec_top_bench;
  logic        clock;
  logic        rst_b;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [31:0] rdata;
  logic [3:0]  line_a;
  logic [3:0]  line_b;
  wire  [3:0]  enc_a;
  wire  [3:0]  enc_b;
  int          miscompares;
  int          checked;
  spec_top DUT (.CLOCK(clock), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .CMD_LINE_A(line_a), .CMD_LINE_B(line_b),
    .ENCODER_PHASE_A(enc_a), .ENCODER_PHASE_B(enc_b));
  spec_far_model far (.CLOCK(clock), .CMD_LINE_A(line_a), .CMD_LINE_B(line_b),
    .ENCODER_PHASE_A(enc_a), .ENCODER_PHASE_B(enc_b));
  task final_report();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string w, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp=%h got=%h", w, exp, got);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_s <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rchk(input string w, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_s <= 1'b0;
    #1;
    chk(w, exp, rdata);
  endtask
  task t_regs();
    chk("lines", 32'hFF, {24'h0, line_a, line_b});
    for (int i = 0; i < 4; i++) begin
      rchk("cfg_rst", 8'(i * 16), 32'h0);
      rchk("cnt_rst", 8'(i * 16 + 8), 32'h0);
    end
    reg_wr(8'h10, 32'h45);
    rchk("cfg_ax0", 8'h00, 32'h0);
    rchk("cfg_ax2", 8'h20, 32'h0);
    rchk("cfg_ax1", 8'h10, 32'h45);
    reg_wr(8'h38, 32'hA5A5_0F0F);
    rchk("cnt_load", 8'h38, 32'hA5A5_0F0F);
    reg_wr(8'h80, 32'h0);
    rchk("version", 8'h80, `SPEC_VERSION_VALUE);
    reg_wr(8'h40, 32'h7F);
    rchk("unmapped", 8'h40, 32'h0);
  endtask
  task t_fmt(input logic [2:0] c, input logic neg);
    logic       idle;
    logic       sw;
    logic       pl;
    logic       ot;
    logic [1:0] nx;
    int         e0;
    idle = (c < 3'h4) ? ~c[0] : (c == 3'h4);
    // Pair formats pulse the second line for negative steps
    sw = c[2] & ~c[1] & neg;
    reg_wr(8'h00, {25'h0, 4'h8, c});
    rchk("cfg_out", 8'h00, {25'h0, 4'h8, c});
    reg_wr(8'h08, 32'h0);
    reg_wr(8'h04, {31'h0, neg});
    repeat (10) @(posedge clock);
    #1;
    e0 = far.edges[0];
    // Next quadrature state after one positive step: lead or lag
    nx = c[0] ? {line_b[0], ~line_a[0]} : {~line_b[0], line_a[0]};
    pl = sw ? line_b[0] : line_a[0];
    if (c < 3'h6) chk("idle_p", {31'h0, idle}, {31'h0, pl});
    repeat (30) @(posedge clock);
    #1;
    pl = sw ? line_b[0] : line_a[0];
    ot = sw ? line_a[0] : line_b[0];
    if (c < 3'h6) chk("act_p", {31'h0, ~idle}, {31'h0, pl});
    if (c < 3'h4) chk("dir_b", {31'h0, (c < 3'h2) ^ neg}, {31'h0, line_b[0]});
    else if (c < 3'h6) chk("idle_o", {31'h0, idle}, {31'h0, ot});
    else chk("quad", {30'h0, nx}, {30'h0, line_a[0], line_b[0]});
    repeat (45) @(posedge clock);
    #1;
    chk("edges", (c < 3'h6) ? 32'h2 : 32'h1, 32'(far.edges[0] - e0));
    rchk("cmd_cnt", 8'h08, neg ? 32'hFFFF_FFFF : 32'h1);
  endtask
  task t_reject();
    reg_wr(8'h00, 32'h40);
    reg_wr(8'h08, 32'h0);
    reg_wr(8'h04, 32'h0);
    reg_wr(8'h04, 32'h1);
    rchk("busy_rej", 8'h0C, 32'h3);
    repeat (90) @(posedge clock);
    rchk("one_step", 8'h08, 32'h1);
    reg_wr(8'h0C, 32'h2);
    rchk("rej_clr", 8'h0C, 32'h0);
  endtask
  task t_enc(input logic [6:0] cfg, input int n, input logic [7:0] pat, input logic [31:0] exp);
    reg_wr(8'h20, {25'h0, cfg});
    far.walk(2, cfg[5], 1, 8'h00);
    reg_wr(8'h28, 32'h0);
    far.walk(2, cfg[5], n, pat);
    repeat (4) @(posedge clock);
    rchk("enc_cnt", 8'h28, exp);
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #(40 * 20000);
    miscompares++;
    final_report();
  end
  initial begin
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    for (int c = 0; c < 8; c++) t_fmt(3'(c), 1'b0);
    t_fmt(3'h0, 1'b1);
    t_fmt(3'h2, 1'b1);
    t_fmt(3'h4, 1'b1);
    t_fmt(3'h5, 1'b1);
    t_reject();
    t_enc(7'h00, 2, 8'hB4, 32'h2);
    t_enc(7'h08, 2, 8'hB4, 32'h4);
    t_enc(7'h10, 2, 8'hB4, 32'h8);
    t_enc(7'h10, 2, 8'h78, 32'hFFFF_FFF8);
    t_enc(7'h18, 2, 8'h88, 32'h4);
    t_enc(7'h18, 2, 8'h44, 32'hFFFF_FFFC);
    t_enc(7'h30, 1, 8'hB4, 32'h4);
    t_enc(7'h50, 2, 8'hB4, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire

// ==== test/spec_top_sva.sv ====
// Port checker for the step pulse and encoder block
`timescale 1ns/1ps
`default_nettype none
`include "spec_cfg.svh"
module spec_top_sva (
  input wire logic        CLOCK,
  input wire logic        RST_B,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic [3:0]  CMD_LINE_A,
  input wire logic [3:0]  CMD_LINE_B,
  input wire logic [3:0]  ENCODER_PHASE_A,
  input wire logic [3:0]  ENCODER_PHASE_B
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // Cycles since the last write; a step sequence lasts 75 cycles
  logic [7:0] quiet_q;
  logic [7:0] quiet_d;
  always_comb begin
    quiet_d = WR ? 8'h00 : ((quiet_q == 8'hFF) ? quiet_q : quiet_q + 8'h01);
  end
  always_ff @(posedge CLOCK) begin
    quiet_q <= RST_B ? quiet_d : 8'h00;
  end
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside answer");
  a_version_ro: assert property (RD && ADDR == `SPEC_ADDR_VERSION
    |=> RDATA == `SPEC_VERSION_VALUE)
    else $error("version value wrong");
  a_unmapped_zero: assert property (RD && ADDR[7:4] == 4'h4 |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_readback: assert property (WR && ADDR[7:6] == 2'h0 && ADDR[3:0] == 4'h0 ##2
    RD && ADDR == $past(ADDR, 2) |=> RDATA[6:0] == $past(WDATA[6:0], 3))
    else $error("setting readback wrong");
  a_count_load: assert property (WR && ADDR == 8'h38 ##2 RD && ADDR == 8'h38
    |=> RDATA == $past(WDATA, 3))
    else $error("counter load readback wrong");
  a_lines_reset: assert property ($rose(RST_B)
    |-> CMD_LINE_A == 4'hF && CMD_LINE_B == 4'hF)
    else $error("lines not idle after reset");
  a_lines_hold: assert property (quiet_q > 8'h64
    |-> $stable(CMD_LINE_A) && $stable(CMD_LINE_B))
    else $error("lines moved without a request");
  a_busy_status: assert property (WR && ADDR == 8'h04 ##2 RD && ADDR == 8'h0C
    |=> RDATA[0])
    else $error("busy not shown after step");
  c_step: cover property (WR && ADDR == 8'h04);
  c_version: cover property (RD && ADDR == `SPEC_ADDR_VERSION);
  c_count_load: cover property (WR && ADDR == 8'h38 ##2 RD && ADDR == 8'h38);
endmodule
bind spec_top spec_top_sva u_sva (.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .CMD_LINE_A(CMD_LINE_A), .CMD_LINE_B(CMD_LINE_B),
  .ENCODER_PHASE_A(ENCODER_PHASE_A), .ENCODER_PHASE_B(ENCODER_PHASE_B));
`default_nettype wire
